// [sim/iemp_props.sv]
// checker: bus timing, reserved bits and reset values at the top ports
`timescale 1ns/100ps
`default_nettype none
module iemp_props (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire iemp_pkg::iemp_wb_req_s       wb_req_i,
  input wire iemp_pkg::iemp_wb_rsp_s       wb_rsp_o,
  input wire logic [iemp_pkg::NUM_IRQ-1:0] sys_event_i,
  input wire logic                         fast_host_interrupt_o,
  input wire logic                         normal_host_interrupt_o
);
  import iemp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [7:0] a);
    wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && wb_req_i.adr == a && !wb_rsp_o.ack;
  endsequence
  property p_ack; wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack; endproperty
  property p_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
  property p_hold; !wb_rsp_o.ack ##1 !wb_rsp_o.ack |-> $stable(wb_rsp_o.dat); endproperty
  property p_hi; (s_rd(8'h0C) or s_rd(8'h1C) or s_rd(8'h2C)) |=> wb_rsp_o.dat[31:5] == 0;
  endproperty
  property p_fidx; s_rd(8'hC0) |=> wb_rsp_o.dat[30:10] == 0
    && (wb_rsp_o.dat[31] || wb_rsp_o.dat[9:0] < NUM_IRQ); endproperty
  property p_nidx; s_rd(8'hC4) |=> wb_rsp_o.dat[30:10] == 0
    && (wb_rsp_o.dat[31] || wb_rsp_o.dat[9:0] < NUM_IRQ); endproperty
  property p_unm; s_rd(8'hA8) |=> wb_rsp_o.dat == 0; endproperty
  property p_rst; $fell(rst_i) |-> !fast_host_interrupt_o && !normal_host_interrupt_o
    && !wb_rsp_o.ack && wb_rsp_o.dat == 0; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_hold: assert property (p_hold) else $error("read data moved without ack");
  a_hi: assert property (p_hi) else $error("high group upper bits set");
  a_fidx: assert property (p_fidx) else $error("fast index malformed");
  a_nidx: assert property (p_nidx) else $error("normal index malformed");
  a_unm: assert property (p_unm) else $error("read past map not zero");
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule : iemp_props
bind iemp_top iemp_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .sys_event_i(sys_event_i), .fast_host_interrupt_o(fast_host_interrupt_o),
  .normal_host_interrupt_o(normal_host_interrupt_o));
`default_nettype wire

// [sim/iemp_sw_master.sv]
// partner: software bus master, one classic wishbone cycle per call
`timescale 1ns/100ps
`default_nettype none
module iemp_sw_master (
  input  wire logic                   clk_i,
  output var  iemp_pkg::iemp_wb_req_s req_o,
  input  wire iemp_pkg::iemp_wb_rsp_s rsp_i
);
  import iemp_pkg::*;
  initial req_o = '0;
  // request held until ack is sampled, then released for at least one cycle
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    req_o <= {1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge clk_i); while (rsp_i.ack !== 1'b1);
    q = rsp_i.dat;
    req_o <= '0;
  endtask : xfer
endmodule : iemp_sw_master
`default_nettype wire

// [sim/tb_interrupt_enable_map_prioritizer.sv]
// testbench: enables, pending clear, channel map and top index through the bus
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_enable_map_prioritizer;
  import iemp_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [NUM_IRQ-1:0] ev    = '0;
  iemp_wb_req_s       req;
  iemp_wb_rsp_s       rsp;
  logic               fast, norm;
  logic [31:0]        q;
  int                 error_cnt = 0;
  int                 cmp_count = 0;
  initial forever #2 clk_i = ~clk_i;
  iemp_sw_master mst (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));
  iemp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .sys_event_i(ev), .fast_host_interrupt_o(fast), .normal_host_interrupt_o(norm));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    mst.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic pulse(input int n);
    @(posedge clk_i);
    ev[n] <= 1'b1;
    @(posedge clk_i);
    ev <= '0;
  endtask : pulse
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic t_reset;
    rd(8'hC0, 32'h8000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
  endtask : t_reset
  task automatic t_enable;
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_001F);
    wr(8'h2C, 32'h0000_0001);
    rd(8'h2C, 32'h0000_001E);
    wr(8'h14, 32'h8000_0000);
    rd(8'h24, 32'h8000_0000);
    wr(8'h10, 32'h0000_0005);
    wr(8'h10, 32'h0000_0000);
    rd(8'h20, 32'h0000_0005);
  endtask : t_enable
  task automatic t_map;
    wr(8'h40, 32'h0302_0100);
    rd(8'h40, 32'h0302_0100);
    wr(8'hA4, 32'hFFFF_FFFF);
    rd(8'hA4, 32'hFFFF_FFFF);
    rd(8'hA8, 32'h0000_0000);
  endtask : t_map
  task automatic t_pending;
    pulse(98);
    pulse(96);
    rd(8'h0C, 32'h0000_0005);
    rd(8'hC0, 32'h0000_0062);
    chk(32'(fast), 32'h0000_0001);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0004);
    rd(8'h0C, 32'h0000_0001);
    rd(8'hC0, 32'h8000_0000);
    chk(32'(fast), 32'h0000_0000);
    wr(8'hA0, 32'h0500_0000);
    pulse(99);
    rd(8'hC4, 32'h0000_0063);
    chk(32'(norm), 32'h0000_0001);
    wr(8'h0C, 32'h0000_0008);
    rd(8'hC4, 32'h8000_0000);
  endtask : t_pending
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_enable();
    t_map();
    t_pending();
    wrap_up();
  end
endmodule : tb_interrupt_enable_map_prioritizer
`default_nettype wire

// [verilog/iemp_pkg.sv]
// package: register map, field layout and bus carriers of the interrupt enable/map/priority block
package iemp_pkg;

  localparam int NUM_IRQ    = 101;
  localparam int PAD_W      = 128 - NUM_IRQ;
  localparam int NUM_FIELDS = 104;
  localparam int ADR_W      = 8;
  localparam int IDX_W      = 10;
  localparam int CHAN_W     = 8;
  localparam int NONE_BIT   = 31;

  // word offsets; each group holds four words, word 3 is the high group (interrupts 96..100)
  localparam logic [ADR_W-1:0] OFS_STATUS_CLEAR_BASE = 8'h00;
  localparam logic [ADR_W-1:0] OFS_ENABLE_SET_BASE   = 8'h10;
  localparam logic [ADR_W-1:0] OFS_ENABLE_CLEAR_BASE = 8'h20;
  localparam logic [ADR_W-1:0] OFS_CHANNEL_MAP_BASE  = 8'h40;
  localparam logic [ADR_W-1:0] OFS_CHANNEL_MAP_LAST  = 8'hA4;
  localparam logic [ADR_W-1:0] OFS_FAST_TOP_INDEX    = 8'hC0;
  localparam logic [ADR_W-1:0] OFS_NORMAL_TOP_INDEX  = 8'hC4;

  localparam logic [3:0] GRP_STATUS_CLEAR = 4'h0;
  localparam logic [3:0] GRP_ENABLE_SET   = 4'h1;
  localparam logic [3:0] GRP_ENABLE_CLEAR = 4'h2;

  // channels up to this value are routed to the fast host interrupt
  localparam logic [CHAN_W-1:0] FAST_CHAN_LAST = 8'h01;
  localparam logic [CHAN_W-1:0] CHAN_RESET     = 8'h00;
  localparam logic [31:0]       DATA_RESET     = 32'h0000_0000;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } iemp_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } iemp_wb_rsp_s;

  typedef struct packed {
    logic             none;
    logic [IDX_W-1:0] idx;
  } iemp_top_s;

endpackage : iemp_pkg

// [verilog/iemp_top.sv]
// module: enable, pending clear, channel map and prioritized index logic with a wishbone slave
//
// How it works
// (RULE_01) high status-clear bit n clears pending n+96
// (RULE_02) status-clear reads show pending before enable gating
// (RULE_03) enable-set bit n enables interrupt n+base
// (RULE_04) enable-clear bit n disables interrupt n+base
// (RULE_05) enable-set/clear reads return current enable bits
// (RULE_06) written zeros leave status and enables unchanged
// (RULE_07) disabled interrupts never raise a host output
// (RULE_08) high group: bits 4-0 only, rest zero
// (RULE_09) 26 map words, four byte fields each
// (RULE_10) map fields read/write, any byte, select channel
// (RULE_11) fast top index shows best fast pending number
// (RULE_12) normal top index shows best normal pending number
// (RULE_13) bit 31 flags none pending; 30-10 zero
// (RULE_14) software clears pending after servicing each interrupt
// (RULE_15) reset clears enables, pending and map fields
`timescale 1ns/100ps
`default_nettype none

module iemp_top (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire iemp_pkg::iemp_wb_req_s        wb_req_i,
  output var  iemp_pkg::iemp_wb_rsp_s        wb_rsp_o,
  input  wire logic [iemp_pkg::NUM_IRQ-1:0]  sys_event_i,
  output var  logic                          fast_host_interrupt_o,
  output var  logic                          normal_host_interrupt_o
);
  import iemp_pkg::*;

  typedef logic [NUM_FIELDS-1:0][CHAN_W-1:0] iemp_map_t;

  logic [NUM_IRQ-1:0]    pending_q;
  logic [NUM_IRQ-1:0]    enable_q;
  iemp_map_t             chan_q;
  iemp_top_s             fast_top_q;
  iemp_top_s             normal_top_q;
  iemp_top_s             fast_top_d;
  iemp_top_s             normal_top_d;
  logic [NUM_IRQ-1:0]    active;
  logic [NUM_IRQ-1:0]    to_fast;
  logic                  req;
  logic                  wr_now;
  logic [3:0]            grp;
  logic [1:0]            word;
  logic [ADR_W-1:0]      map_off;
  logic [4:0]            map_idx;
  logic                  map_hit;
  logic [31:0]           wmask;
  logic [NUM_IRQ-1:0]    wbits;
  logic [31:0]           rd_data;

  // pick one 32-bit word out of a per-interrupt vector; bits beyond 100 read zero
  function automatic logic [31:0] word_of(input logic [NUM_IRQ-1:0] v, input logic [1:0] k);
    logic [127:0] w;
    w = {{PAD_W{1'b0}}, v};
    return w[32*k +: 32];
  endfunction : word_of

  // place a written word at its group position; bits beyond 100 are dropped
  function automatic logic [NUM_IRQ-1:0] spread(input logic [31:0] d, input logic [1:0] k);
    logic [127:0] w;
    w = '0;
    w[32*k +: 32] = d;
    return w[NUM_IRQ-1:0];
  endfunction : spread

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // lowest channel wins; among equal channels the lowest interrupt number wins
  function automatic iemp_top_s pick(input logic [NUM_IRQ-1:0] act, input iemp_map_t chans);
    iemp_top_s         t;
    logic [CHAN_W-1:0] best;
    t.none = 1'b1;
    t.idx  = '0;
    best   = '1;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (act[i] && (t.none || chans[i] < best)) begin
        t.none = 1'b0;
        t.idx  = IDX_W'(i);
        best   = chans[i];
      end
    end
    return t;
  endfunction : pick

  // bus decode
  assign req     = wb_req_i.cyc && wb_req_i.stb;
  assign wr_now  = req && wb_req_i.we && wb_rsp_o.ack;
  assign grp     = wb_req_i.adr[7:4];
  assign word    = wb_req_i.adr[3:2];
  assign map_off = wb_req_i.adr - OFS_CHANNEL_MAP_BASE;
  assign map_idx = map_off[6:2];
  assign map_hit = (wb_req_i.adr >= OFS_CHANNEL_MAP_BASE) &&
                   (wb_req_i.adr <= OFS_CHANNEL_MAP_LAST);
  assign wmask   = lane_mask(wb_req_i.sel);
  assign wbits   = spread(wb_req_i.dat & wmask, word);  // see RULE_08

  // routing and gating
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      to_fast[i] = chan_q[i] <= FAST_CHAN_LAST;  // see RULE_10
    end
  end

  assign active       = pending_q & enable_q;  // see RULE_07
  assign fast_top_d   = pick(active & to_fast, chan_q);  // see RULE_11
  assign normal_top_d = pick(active & ~to_fast, chan_q);  // see RULE_12

  // read mux
  always_comb begin
    rd_data = DATA_RESET;
    if (map_hit) begin
      rd_data = chan_q[4*map_idx +: 4];  // see RULE_09
    end else if (wb_req_i.adr == OFS_FAST_TOP_INDEX) begin
      rd_data[NONE_BIT]    = fast_top_q.none;  // see RULE_13
      rd_data[IDX_W-1:0]   = fast_top_q.idx;  // see RULE_11
    end else if (wb_req_i.adr == OFS_NORMAL_TOP_INDEX) begin
      rd_data[NONE_BIT]    = normal_top_q.none;  // see RULE_13
      rd_data[IDX_W-1:0]   = normal_top_q.idx;  // see RULE_12
    end else if (wb_req_i.adr[1:0] == 2'b00) begin
      case (grp)
        GRP_STATUS_CLEAR: rd_data = word_of(pending_q, word);  // see RULE_02
        GRP_ENABLE_SET:   rd_data = word_of(enable_q, word);  // see RULE_05
        GRP_ENABLE_CLEAR: rd_data = word_of(enable_q, word);  // see RULE_05
        default:          rd_data = DATA_RESET;
      endcase
    end
  end

  // wishbone answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '0;
    end else begin
      wb_rsp_o.ack <= req && !wb_rsp_o.ack;
      if (req && !wb_rsp_o.ack) begin
        wb_rsp_o.dat <= rd_data;
      end
    end
  end

  // pending status: hardware events win over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_q <= '0;  // see RULE_15
    end else if (wr_now && grp == GRP_STATUS_CLEAR && !map_hit) begin
      pending_q <= (pending_q & ~wbits) | sys_event_i;  // see RULE_01, RULE_06
    end else begin
      pending_q <= pending_q | sys_event_i;
    end
  end

  // per-interrupt enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= '0;  // see RULE_15
    end else if (wr_now && grp == GRP_ENABLE_SET && !map_hit) begin
      enable_q <= enable_q | wbits;  // see RULE_03, RULE_06
    end else if (wr_now && grp == GRP_ENABLE_CLEAR && !map_hit) begin
      enable_q <= enable_q & ~wbits;  // see RULE_04, RULE_06
    end
  end

  // channel map fields, one byte lane each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q <= '{default: CHAN_RESET};  // see RULE_15
    end else if (wr_now && map_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_req_i.sel[b]) begin
          chan_q[4*map_idx + b] <= wb_req_i.dat[8*b +: 8];  // see RULE_10
        end
      end
    end
  end

  // prioritized indices and host outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_top_q              <= '{none: 1'b1, idx: '0};
      normal_top_q            <= '{none: 1'b1, idx: '0};
      fast_host_interrupt_o   <= 1'b0;
      normal_host_interrupt_o <= 1'b0;
    end else begin
      fast_top_q              <= fast_top_d;
      normal_top_q            <= normal_top_d;
      fast_host_interrupt_o   <= !fast_top_d.none;  // see RULE_07
      normal_host_interrupt_o <= !normal_top_d.none;  // see RULE_07
    end
  end

endmodule : iemp_top

`default_nettype wire
